/* File: hdl/pulse_config_pkg.sv */
package pulse_config_pkg;

   // Printed offsets are register indices; byte address is four times the index
   localparam logic [29:0] INDEX_PULSE_MODE = 30'h0000E610;
   localparam logic [29:0] INDEX_PHASE_A    = 30'h0000E614;
   localparam logic [29:0] INDEX_PHASE_B    = 30'h0000E615;
   localparam logic [29:0] INDEX_PHASE_C    = 30'h0000E616;

   localparam int NUM_OUTPUTS   = 3;
   localparam int NUM_PHASES    = 3;
   localparam int NUM_QUANTITY  = 5;
   localparam int REG_WIDTH     = 16;

   localparam int SEL1_LSB      = 0;
   localparam int SEL2_LSB      = 3;
   localparam int SEL3_LSB      = 6;
   localparam int DISABLE_LSB   = 9;
   localparam int LATCH_LSB     = 12;
   localparam int SPARE_BIT     = 15;
   localparam int COMP_WIDTH    = 10;

   localparam logic [15:0] PULSE_MODE_RESET = 16'h0E88;
   localparam logic [15:0] PHASE_COMP_RESET = 16'h0000;

   localparam logic [2:0] QTY_TOTAL_ACTIVE   = 3'h0;
   localparam logic [2:0] QTY_TOTAL_REACTIVE = 3'h1;
   localparam logic [2:0] QTY_APPARENT       = 3'h2;
   localparam logic [2:0] QTY_FUND_ACTIVE    = 3'h3;
   localparam logic [2:0] QTY_FUND_REACTIVE  = 3'h4;

   localparam logic [1:0] ALIAS_CODE = 2'h3;

   typedef struct packed {
      logic       spare;
      logic [2:0] energy_latch;
      logic [2:0] pin_disable;
      logic [2:0] pulse3_quantity_select;
      logic [2:0] pulse2_quantity_select;
      logic [2:0] pulse1_quantity_select;
   } pulse_mode_type;

   typedef struct packed {
      logic       on_voltage;
      logic [8:0] amount;
   } phase_comp_type;

endpackage

/* File: hdl/phase_comp_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module phase_comp_decode
   import pulse_config_pkg::*;
(
   input  wire logic [15:0]    comp_reg_in,
   output phase_comp_type      comp_out
);

   logic [COMP_WIDTH-1:0] phase_comp_value;

   // Bits above the value are ignored
   assign phase_comp_value = comp_reg_in[COMP_WIDTH-1:0];

   always_comb
   begin
      // Upper half selects voltage channel
      comp_out.on_voltage = phase_comp_value[9];
      // Top quarter of each half aliases onto its first 128 codes
      if (phase_comp_value[8:7] == ALIAS_CODE)
         comp_out.amount = {2'h0, phase_comp_value[6:0]};
      else
         comp_out.amount = phase_comp_value[8:0];
   end

endmodule
`default_nettype wire

/* File: hdl/pulse_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module pulse_channel
   import pulse_config_pkg::*;
#(
   parameter int POWER_WIDTH = 24
)
(
   input  wire logic                          clock_in,
   input  wire logic                          srst_in,
   input  wire logic [2:0]                    quantity_select_in,
   input  wire logic [NUM_PHASES-1:0]         phase_include_in,
   input  wire logic signed [POWER_WIDTH-1:0] power_in [NUM_QUANTITY][NUM_PHASES],
   output logic                               select_valid_out,
   output logic signed [POWER_WIDTH+1:0]      sum_out
);

   logic signed [POWER_WIDTH+1:0] term [NUM_PHASES];
   logic signed [POWER_WIDTH+1:0] next_sum;

   // Codes 101..111 are reserved and stop the converter
   assign select_valid_out = (quantity_select_in <= QTY_FUND_REACTIVE);

   genvar p;
   generate
      for (p = 0; p < NUM_PHASES; p++)
      begin : g_term
         // Included phases add their power; excluded ones add zero
         assign term[p] = (phase_include_in[p] && select_valid_out)
                        ? (POWER_WIDTH+2)'(power_in[quantity_select_in][p])
                        : '0;
      end
   endgenerate

   assign next_sum = term[0] + term[1] + term[2];

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
         sum_out <= '0;
      else
         sum_out <= next_sum;
   end

endmodule
`default_nettype wire

/* File: hdl/pulse_output_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module pulse_output_config_regs
   import pulse_config_pkg::*;
#(
   parameter int POWER_WIDTH = 24
)
(
   input  wire logic                          clock_in,
   input  wire logic                          srst_in,
   input  wire logic                          hsel_in,
   input  wire logic [31:0]                   haddr_in,
   input  wire logic [1:0]                    htrans_in,
   input  wire logic                          hwrite_in,
   input  wire logic [2:0]                    hsize_in,
   input  wire logic                          hready_in,
   input  wire logic [31:0]                   hwdata_in,
   output logic                               hreadyout_out,
   output logic                               hresp_out,
   output logic [31:0]                        hrdata_out,
   input  wire logic [8:0]                    phase_include_in,
   input  wire logic [NUM_OUTPUTS-1:0]        converter_pulse_in,
   input  wire logic signed [POWER_WIDTH-1:0] power_in [NUM_QUANTITY][NUM_PHASES],
   output logic [NUM_OUTPUTS-1:0]             converter_enable_out,
   output logic [NUM_OUTPUTS-1:0]             pulse_pin_out,
   output logic [NUM_OUTPUTS-1:0]             energy_latch_strobe_out,
   output logic signed [POWER_WIDTH+1:0]      channel_sum_out [NUM_OUTPUTS],
   output phase_comp_type                     phase_comp_out [NUM_PHASES]
);

   generate
      if (POWER_WIDTH < 2 || POWER_WIDTH > 60)
      begin : g_width_check
         $error("POWER_WIDTH out of range");
      end
   endgenerate

   pulse_mode_type              pulse_output_mode;
   logic [REG_WIDTH-1:0]        comp_reg [NUM_PHASES];
   logic                        data_write;
   logic                        data_hit;
   logic [1:0]                  data_slot;
   logic                        addr_valid;
   logic                        addr_hit;
   logic [1:0]                  addr_slot;
   logic [REG_WIDTH-1:0]        next_read;
   logic [2:0]                  quantity_select [NUM_OUTPUTS];
   logic [NUM_OUTPUTS-1:0]      select_valid;
   phase_comp_type              comp_decoded [NUM_PHASES];

   // Zero-wait slave: never stalls and never errors
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   assign addr_valid = hsel_in && htrans_in[1] && hready_in;

   always_comb
   begin
      addr_hit  = 1'b1;
      addr_slot = 2'h0;
      case (haddr_in[31:2])
         INDEX_PULSE_MODE : addr_slot = 2'h0;
         INDEX_PHASE_A    : addr_slot = 2'h1;
         INDEX_PHASE_B    : addr_slot = 2'h2;
         INDEX_PHASE_C    : addr_slot = 2'h3;
         default          : addr_hit  = 1'b0;
      endcase
   end

   // Address phase captured for the following data phase
   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         data_write <= 1'b0;
         data_hit   <= 1'b0;
         data_slot  <= 2'h0;
      end
      else if (hready_in)
      begin
         data_write <= addr_valid && hwrite_in;
         data_hit   <= addr_valid && addr_hit;
         data_slot  <= addr_slot;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
         pulse_output_mode <= pulse_mode_type'(PULSE_MODE_RESET);
      else if (data_write && data_hit && data_slot == 2'h0)
         pulse_output_mode <= pulse_mode_type'(hwdata_in[REG_WIDTH-1:0]);
   end

   genvar i;
   generate
      for (i = 0; i < NUM_PHASES; i++)
      begin : g_comp
         always_ff @(posedge clock_in)
         begin
            if (srst_in)
               comp_reg[i] <= PHASE_COMP_RESET;
            else if (data_write && data_hit && data_slot == 2'(i + 1))
               comp_reg[i] <= hwdata_in[REG_WIDTH-1:0];
         end

         phase_comp_decode u_decode (
            .comp_reg_in (comp_reg[i]),
            .comp_out    (comp_decoded[i])
         );

         // Registered so downstream filters see a clean value
         always_ff @(posedge clock_in)
         begin
            if (srst_in)
               phase_comp_out[i] <= '0;
            else
               phase_comp_out[i] <= comp_decoded[i];
         end
      end
   endgenerate

   // A read right behind a write to the same word sees the new value
   always_comb
   begin
      next_read = '0;
      if (data_write && data_hit && data_slot == addr_slot)
         next_read = hwdata_in[REG_WIDTH-1:0];
      else
      begin
         case (addr_slot)
            2'h0    : next_read = pulse_output_mode;
            2'h1    : next_read = comp_reg[0];
            2'h2    : next_read = comp_reg[1];
            2'h3    : next_read = comp_reg[2];
            default : next_read = '0;
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
         hrdata_out <= '0;
      else if (addr_valid && !hwrite_in)
         hrdata_out <= addr_hit ? {16'h0000, next_read} : 32'h0000_0000;
   end

   assign quantity_select[0] = pulse_output_mode.pulse1_quantity_select;
   assign quantity_select[1] = pulse_output_mode.pulse2_quantity_select;
   assign quantity_select[2] = pulse_output_mode.pulse3_quantity_select;

   genvar k;
   generate
      for (k = 0; k < NUM_OUTPUTS; k++)
      begin : g_out
         pulse_channel #(
            .POWER_WIDTH (POWER_WIDTH)
         ) u_channel (
            .clock_in           (clock_in),
            .srst_in            (srst_in),
            .quantity_select_in (quantity_select[k]),
            .phase_include_in   (phase_include_in[3*k +: 3]),
            .power_in           (power_in),
            .select_valid_out   (select_valid[k]),
            .sum_out            (channel_sum_out[k])
         );

         // Converter runs whatever the pin disable says
         assign converter_enable_out[k] = select_valid[k];

         always_ff @(posedge clock_in)
         begin
            if (srst_in)
               pulse_pin_out[k] <= 1'b0;
            else
               pulse_pin_out[k] <= converter_pulse_in[k] && select_valid[k]
                                   && !pulse_output_mode.pin_disable[k];
         end

         // Latch follows the converter pulse, even with the pin disabled
         always_ff @(posedge clock_in)
         begin
            if (srst_in)
               energy_latch_strobe_out[k] <= 1'b0;
            else
               energy_latch_strobe_out[k] <= converter_pulse_in[k] && select_valid[k]
                                             && pulse_output_mode.energy_latch[k];
         end
      end
   endgenerate

   default clocking cb @(posedge clock_in);
   endclocking

   default disable iff (srst_in);

   a_mode_reset_value: assert property (
      $fell(srst_in) |-> pulse_output_mode == pulse_mode_type'(PULSE_MODE_RESET))
      else $error("pulse mode register left reset with wrong value");

   a_reserved_no_pulse: assert property (
      (pulse_output_mode.pulse1_quantity_select > QTY_FUND_REACTIVE)
      |=> !pulse_pin_out[0] && !energy_latch_strobe_out[0])
      else $error("pulse produced under reserved select code");

   a_disable_blocks_pin: assert property (
      pulse_output_mode.pin_disable[0] |=> !pulse_pin_out[0])
      else $error("pin pulsed while disabled");

   a_enable_passes_pulse: assert property (
      converter_pulse_in[1] && select_valid[1] && !pulse_output_mode.pin_disable[1]
      |=> pulse_pin_out[1])
      else $error("enabled pin missed a converter pulse");

   a_converter_runs: assert property (
      pulse_output_mode.pin_disable[2] && select_valid[2] |-> converter_enable_out[2])
      else $error("converter stopped by pin disable");

   a_latch_on_pulse: assert property (
      converter_pulse_in[0] && select_valid[0] && pulse_output_mode.energy_latch[0]
      |=> energy_latch_strobe_out[0])
      else $error("energy latch missed on pulse");

   a_no_latch_clear: assert property (
      !pulse_output_mode.energy_latch[1] |=> !energy_latch_strobe_out[1])
      else $error("latch strobe with latch bit clear");

   a_alias_current: assert property (
      comp_reg[0][9:7] == 3'h3 |=> phase_comp_out[0].amount == {2'h0, $past(comp_reg[0][6:0])}
                                   && !phase_comp_out[0].on_voltage)
      else $error("current alias range decoded wrongly");

   a_alias_voltage: assert property (
      comp_reg[1][9:7] == 3'h7 |=> phase_comp_out[1].amount == {2'h0, $past(comp_reg[1][6:0])}
                                   && phase_comp_out[1].on_voltage)
      else $error("voltage alias range decoded wrongly");

   a_comp_upper_ignored: assert property (
      $changed(comp_reg[2][15:10]) && $stable(comp_reg[2][9:0]) |=> $stable(phase_comp_out[2]))
      else $error("reserved compensation bits changed the decode");

   a_write_read_back: assert property (
      data_write && data_hit && data_slot == 2'h1 ##1 addr_valid && !hwrite_in
      && addr_hit && addr_slot == 2'h1 && !(data_write && data_hit)
      |=> hrdata_out == {16'h0000, $past(hwdata_in[15:0], 2)})
      else $error("read back differs from written value");

   a_unmapped_zero: assert property (
      addr_valid && !hwrite_in && !addr_hit |=> hrdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_sel2_reset_value: assert property (
      $fell(srst_in) |-> pulse_output_mode.pulse2_quantity_select == 3'h1)
      else $error("output 2 select left reset with wrong value");

   a_sel3_reset_value: assert property (
      $fell(srst_in) |-> pulse_output_mode.pulse3_quantity_select == 3'h2)
      else $error("output 3 select left reset with wrong value");

   a_spare_reset_zero: assert property (
      $fell(srst_in) |-> !pulse_output_mode.spare)
      else $error("spare mode bit left reset set");

   // Spare bit may toggle alone; converter_enable_out may not move
   a_spare_no_effect: assert property (
      $changed(pulse_output_mode.spare) && $stable(pulse_output_mode[14:0])
      |-> $stable(converter_enable_out))
      else $error("spare mode bit changed converter state");

   a_reserved_sum_zero: assert property (
      pulse_output_mode.pulse3_quantity_select > QTY_FUND_REACTIVE
      |=> channel_sum_out[2] == '0)
      else $error("sum not cleared under reserved select code");

   a_disable2_blocks_pin: assert property (
      pulse_output_mode.pin_disable[1] |=> !pulse_pin_out[1])
      else $error("pin 2 pulsed while disabled");

   // Pin pulses only ever follow a converter pulse
   a_pin_needs_converter: assert property (
      pulse_pin_out[2]
      |-> $past(converter_pulse_in[2]) && !$past(pulse_output_mode.pin_disable[2]))
      else $error("pin 3 pulsed without an enabled converter pulse");

   a_latch3_on_pulse: assert property (
      converter_pulse_in[2] && select_valid[2] && pulse_output_mode.energy_latch[2]
      |=> energy_latch_strobe_out[2])
      else $error("output 3 energy latch missed on pulse");

   a_no_latch3_clear: assert property (
      !pulse_output_mode.energy_latch[2] |=> !energy_latch_strobe_out[2])
      else $error("output 3 latch strobe with latch bit clear");

   // Direct current range passes through unchanged
   a_comp_current_direct: assert property (
      comp_reg[1][9:7] < 3'h3
      |=> phase_comp_out[1].amount == $past(comp_reg[1][8:0])
          && !phase_comp_out[1].on_voltage)
      else $error("current range decoded wrongly");

   a_comp_voltage_range: assert property (
      comp_reg[2][9] && comp_reg[2][8:7] != 2'h3
      |=> phase_comp_out[2].on_voltage
          && phase_comp_out[2].amount == $past(comp_reg[2][8:0]))
      else $error("voltage range decoded wrongly");

   a_mode_write_lands: assert property (
      data_write && data_hit && data_slot == 2'h0
      |=> pulse_output_mode == $past(hwdata_in[REG_WIDTH-1:0]))
      else $error("mode write did not land");

   c_reserved_select: cover property (
      pulse_output_mode.pulse2_quantity_select == 3'h6 && converter_pulse_in[1]);

   c_latch_disabled_pin: cover property (
      pulse_output_mode.pin_disable[2] ##1 energy_latch_strobe_out[2]);

   c_voltage_comp: cover property (phase_comp_out[0].on_voltage);

   c_back_to_back: cover property (data_write && data_hit && addr_valid && !hwrite_in);

   c_spare_toggle: cover property ($changed(pulse_output_mode.spare));

endmodule
`default_nettype wire

/* File: verification/front_end_model.sv */
`timescale 1ns/100ps
`default_nettype none
module front_end_model
   import pulse_config_pkg::*;
#(
   parameter int POWER_WIDTH = 24
)
(
   output logic signed [POWER_WIDTH-1:0] power_out [NUM_QUANTITY][NUM_PHASES]
);
   // Distinct value per quantity and phase; phase B negative to exercise signed sums
   always_comb
   begin
      for (int q = 0; q < NUM_QUANTITY; q++)
      begin
         for (int p = 0; p < NUM_PHASES; p++)
         begin
            power_out[q][p] = POWER_WIDTH'((p == 1 ? -1 : 1) * (q * 3 + p + 1) * 1000);
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/pulse_output_config_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pulse_output_config_regs_tb_top;
   import pulse_config_pkg::*;
   logic               clock_in = 1'b0;
   logic               srst_in = 1'b1;
   logic               hsel = 1'b0;
   logic               hwrite = 1'b0;
   logic [1:0]         htrans = 2'h0;
   logic [31:0]        haddr = 32'h0;
   logic [31:0]        hwdata = 32'h0;
   logic [8:0]         phase_inc = 9'h1FF;
   logic [2:0]         fire = 3'h0;
   logic               hreadyout;
   logic               hresp;
   logic [31:0]        hrdata;
   logic [2:0]         conv_en;
   logic [2:0]         pin;
   logic [2:0]         strobe;
   logic signed [23:0] power [NUM_QUANTITY][NUM_PHASES];
   logic signed [25:0] sums [NUM_OUTPUTS];
   phase_comp_type     comp [NUM_PHASES];
   logic [31:0]        addr [4];
   int                 errors = 0;
   int                 samples_checked = 0;

   assign addr[0] = {INDEX_PULSE_MODE, 2'b00};
   assign addr[1] = {INDEX_PHASE_A, 2'b00};
   assign addr[2] = {INDEX_PHASE_B, 2'b00};
   assign addr[3] = {INDEX_PHASE_C, 2'b00};

   always #5 clock_in = ~clock_in;

   front_end_model front_end_model_i (.power_out(power));

   pulse_output_config_regs pulse_output_config_regs_i (
      .clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout),
      .hwdata_in(hwdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
      .hrdata_out(hrdata), .phase_include_in(phase_inc), .converter_pulse_in(fire),
      .power_in(power), .converter_enable_out(conv_en), .pulse_pin_out(pin),
      .energy_latch_strobe_out(strobe), .channel_sum_out(sums), .phase_comp_out(comp));

   task automatic final_report();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_sum(input logic signed [25:0] got, input logic signed [25:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected sum at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Master holds each phase until hready is seen high at an edge
   task automatic ahb_phase(input logic [31:0] a, input logic w);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock_in); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
   endtask

   task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
      ahb_phase(a, 1'b1);
      hwdata <= d;
      do @(posedge clock_in); while (hreadyout !== 1'b1);
   endtask

   task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
      ahb_phase(a, 1'b0);
      do @(posedge clock_in); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask

   function automatic logic signed [23:0] pwr(input int q, input int p);
      int v;
      v = (q * 3 + p + 1) * 1000;
      return 24'(p == 1 ? -v : v);
   endfunction

   function automatic logic signed [25:0] exp_sum(input int q, input logic [2:0] inc);
      logic signed [25:0] s;
      s = '0;
      if (q > 4)
         return s;
      for (int p = 0; p < 3; p++)
         if (inc[p])
            s += 26'(pwr(q, p));
      return s;
   endfunction

   // Pulse all converters for one cycle, then look at pins one cycle later
   task automatic pulse_check(input logic [2:0] exp_pin, input logic [2:0] exp_strobe);
      fire <= 3'h7;
      @(posedge clock_in);
      fire <= 3'h0;
      #1;
      check_word({29'h0, pin}, {29'h0, exp_pin});
      check_word({29'h0, strobe}, {29'h0, exp_strobe});
   endtask

   task automatic check_sums(input int q0, input int q1, input int q2);
      check_sum(sums[0], exp_sum(q0, phase_inc[2:0]));
      check_sum(sums[1], exp_sum(q1, phase_inc[5:3]));
      check_sum(sums[2], exp_sum(q2, phase_inc[8:6]));
   endtask

   initial
   begin
      #100000;
      errors++;
      final_report();
   end

   initial
   begin
      logic [31:0] rd;
      logic [9:0]  v;
      logic [8:0]  amt;
      logic [2:0]  en;
      logic [9:0]  vals [8];
      vals = '{10'd0, 10'd383, 10'd384, 10'd511, 10'd512, 10'd895, 10'd896, 10'd1023};
      repeat (2) @(posedge clock_in);
      srst_in <= 1'b0;
      @(posedge clock_in);
      for (int i = 0; i < 4; i++)
      begin
         ahb_read(addr[i], rd);
         check_word(rd, i == 0 ? 32'h00000E88 : 32'h00000000);
         check_word({31'h0, hresp}, 32'h00000000);
      end
      pulse_check(3'h0, 3'h0);
      check_word({29'h0, conv_en}, 32'h00000007);
      @(posedge clock_in);
      ahb_write(32'h0003985C, 32'h0000FFFF);
      ahb_read(32'h0003985C, rd);
      check_word(rd, 32'h00000000);
      for (int j = 0; j < 8; j++)
      begin
         v = vals[j];
         ahb_write(addr[1 + j % 3], {16'hA5A5, 6'h3F, v});
         ahb_read(addr[1 + j % 3], rd);
         check_word(rd, {16'h0, 6'h3F, v});
         amt = (v[8:0] >= 9'd384) ? v[8:0] - 9'd384 : v[8:0];
         #1;
         check_word({22'h0, comp[j % 3]}, {22'h0, v[9], amt});
         @(posedge clock_in);
      end
      ahb_write(addr[3], {16'h0000, 6'h15, 10'h37F});
      ahb_read(addr[3], rd);
      check_word(rd, {16'h0000, 6'h15, 10'h37F});
      #1;
      check_word({22'h0, comp[2]}, {22'h0, 1'b1, 9'h17F});
      @(posedge clock_in);
      phase_inc <= 9'b111_011_101;
      for (int code = 0; code < 8; code++)
      begin
         en = (code <= 4) ? 3'h7 : 3'h0;
         ahb_write(addr[0], {4'hF, 3'h0, 3'(code), 3'(code), 3'(code)});
         pulse_check(en, en);
         check_word({29'h0, conv_en}, {29'h0, en});
         check_sums(code, code, code);
         @(posedge clock_in);
      end
      ahb_write(addr[0], {4'h2, 3'h5, 3'h4, 3'h3, 3'h0});
      phase_inc <= 9'b100_010_111;
      pulse_check(3'h2, 3'h2);
      check_word({29'h0, conv_en}, 32'h00000007);
      check_sums(0, 3, 4);
      @(posedge clock_in);
      ahb_write(addr[0], {4'hA, 3'h5, 3'h4, 3'h3, 3'h0});
      pulse_check(3'h2, 3'h2);
      check_word({29'h0, conv_en}, 32'h00000007);
      check_sums(0, 3, 4);
      @(posedge clock_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      srst_in <= 1'b0;
      @(posedge clock_in);
      ahb_read(addr[0], rd);
      check_word(rd, 32'h00000E88);
      final_report();
   end
endmodule
`default_nettype wire
